// >>> rtl/pulse_counter_pkg.sv
// Shared constants and types of the pulse counter and alarm block.
// Assumes one 125 MHz clock; all times are converted to cycles here.
package pulse_counter_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ           = 125;
    localparam int CLK_HZ            = CLK_MHZ * 1000000;
    localparam int MIN_PULSE_CNT_US  = 100;
    localparam int MIN_PULSE_FREQ_US = 500;
    localparam int MIN_PULSE_CNT_CYC  = MIN_PULSE_CNT_US * CLK_MHZ;
    localparam int MIN_PULSE_FREQ_CYC = MIN_PULSE_FREQ_US * CLK_MHZ;
    localparam int FREQ_MIN_MILLIHZ  = 300;
    localparam int FREQ_MAX_HZ       = 1000;
    localparam int CNT_MAX_HZ        = 5000;
    // Longest period still measured, rounded down
    localparam int FREQ_TIMEOUT_CYC  = (CLK_HZ / FREQ_MIN_MILLIHZ) * 1000;

    // ------------------------------------------------------------
    // Widths, count range and reset values
    // ------------------------------------------------------------
    localparam int COUNT_W = 32;
    localparam int TALLY_W = 16;
    localparam int SLOT_W  = 4;
    localparam int CHAN_W  = 4;
    localparam int PERIOD_W = 32;
    localparam logic [COUNT_W-1:0] COUNT_MIN  = 32'h0000_0000;
    localparam logic [COUNT_W-1:0] COUNT_MAX  = 32'hFFFF_FFFF;
    localparam logic [COUNT_W-1:0] COUNT_RST  = 32'h0000_0000;
    localparam logic [PERIOD_W-1:0] PERIOD_RST = 32'h0000_0000;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_UPDOWN = 2'b00,
        MODE_BIDIR  = 2'b01,
        MODE_FREQ   = 2'b10
    } countMode_t;

    typedef enum logic {
        ALARM_DISABLE = 1'b0,
        ALARM_LATCH   = 1'b1
    } alarmState_t;

    typedef struct packed {
        logic [COUNT_W-1:0] initValue;
        logic [COUNT_W-1:0] hiLimit;
        logic [COUNT_W-1:0] loLimit;
        alarmState_t        hiState;
        alarmState_t        loState;
        logic               hiOutEn;
        logic [SLOT_W-1:0]  hiOutSlot;
        logic [CHAN_W-1:0]  hiOutChan;
    } chanCfg_t;

    typedef struct packed {
        logic              active;
        logic [SLOT_W-1:0] slot;
        logic [CHAN_W-1:0] chan;
    } alarmRoute_t;

endpackage : pulse_counter_pkg

// >>> rtl/pulse_input_filter.sv
// Minimum-width filter and rising-edge detector for one field input pair.
// Assumes the input pair is already synchronous to clock.
`timescale 1ns/100ps
`default_nettype none

module pulse_input_filter #(
    parameter int CW = 20
) (
    input  wire logic          clock,
    input  wire logic          sys_rst,
    input  wire logic          inPos,
    input  wire logic          inNeg,
    input  wire logic [CW-1:0] minWidthCyc,
    output logic               level_q,
    output logic               rise_q
);

    // ------------------------------------------------------------
    // Stability counter
    // ------------------------------------------------------------
    logic [CW-1:0] stable_q;
    wire logic     rawLevel = inPos & ~inNeg;
    wire logic     differs  = rawLevel != level_q;
    wire logic     accept   = differs && (stable_q >= minWidthCyc - CW'(1));

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            stable_q <= '0;
            level_q  <= 1'b0;
            rise_q   <= 1'b0;
        end else begin
            rise_q <= accept & rawLevel;
            if (!differs || accept) begin
                stable_q <= '0;
            end else begin
                stable_q <= stable_q + CW'(1);
            end
            if (accept) begin
                level_q <= rawLevel;
            end
        end
    end

endmodule : pulse_input_filter

`default_nettype wire

// >>> rtl/pulse_counter_overflow_alarm.sv
// Multi-channel pulse counter, frequency meter and limit alarm.
// Assumes synchronous field inputs and configuration held steady by the host.
`timescale 1ns/100ps
`default_nettype none

// Contract
// - Tally goes up on passing above max, down on passing below min.
// - Leaving the range reloads the count with the initial value.
// - Count is 32-bit unsigned, fixed range 0 to 4,294,967,295.
// - High alarm state is latch or disable; disable gives no alarm.
// - Any high limit 0 to 4,294,967,295 is compared with the count.
// - High alarm output mode enables or disables forwarding to an output.
// - Forwarded alarm goes to the host-chosen output slot and channel.
// - Clear control releases latched alarm, then returns to disabled itself.
// - Frequency 0.3 to 1000 Hz measured; counting up to 5000 Hz.
// - Pulses down to 500 us (frequency) and 100 us (counter) accepted.
// - Latched alarm holds until cleared even if count returns in range.
// - Up/down mode: up edge adds, down edge subtracts, both together hold.
// - Bidirectional mode: direction high counts up, low counts down.
// - One mode, counter or frequency, applies to all channels.
module pulse_counter_overflow_alarm
    import pulse_counter_pkg::*;
#(
    parameter int NCH                = 4,
    parameter int FILT_W             = 20,
    parameter int TALLY_BITS         = pulse_counter_pkg::TALLY_W,
    parameter int MIN_PULSE_CNT_CYC  = pulse_counter_pkg::MIN_PULSE_CNT_CYC,
    parameter int MIN_PULSE_FREQ_CYC = pulse_counter_pkg::MIN_PULSE_FREQ_CYC,
    parameter int FREQ_TIMEOUT_CYC   = pulse_counter_pkg::FREQ_TIMEOUT_CYC
) (
    input  wire logic                                          clock,
    input  wire logic                                          sys_rst,
    input  wire pulse_counter_pkg::countMode_t                 countMode,
    input  wire pulse_counter_pkg::chanCfg_t [NCH-1:0]         chanCfg,
    input  wire logic [NCH-1:0]                                loadInitReq,
    input  wire logic [NCH-1:0]                                clearLatchReq,
    input  wire logic [NCH-1:0]                                up_pulse_input_pos,
    input  wire logic [NCH-1:0]                                up_pulse_input_neg,
    input  wire logic [NCH-1:0]                                down_or_direction_input_pos,
    input  wire logic [NCH-1:0]                                down_or_direction_input_neg,
    output logic [NCH-1:0][pulse_counter_pkg::COUNT_W-1:0]     countVal_q,
    output logic [NCH-1:0][TALLY_BITS-1:0]                     overflowTally_q,
    output logic [NCH-1:0]                                     hiAlarm_q,
    output logic [NCH-1:0]                                     loAlarm_q,
    output logic [NCH-1:0]                                     clearLatchCtl_q,
    output pulse_counter_pkg::alarmRoute_t [NCH-1:0]           hiAlarmRoute_q,
    output logic [NCH-1:0][pulse_counter_pkg::PERIOD_W-1:0]    freqPeriod_q
);

    import pulse_counter_pkg::*;

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (NCH < 1) begin : gNchCheck
        $error("NCH must be at least 1");
    end
    if (MIN_PULSE_CNT_CYC < 1 || MIN_PULSE_FREQ_CYC < 1) begin : gWidthCheck
        $error("Minimum pulse widths must be at least one cycle");
    end
    if (MIN_PULSE_CNT_CYC >= (1 << FILT_W) || MIN_PULSE_FREQ_CYC >= (1 << FILT_W)) begin : gFiltCheck
        $error("FILT_W too narrow for minimum pulse widths");
    end
    if (TALLY_BITS < 2) begin : gTallyCheck
        $error("TALLY_BITS must be at least 2");
    end
    if (FREQ_TIMEOUT_CYC < 2) begin : gTimeoutCheck
        $error("FREQ_TIMEOUT_CYC must be at least 2");
    end

    // ------------------------------------------------------------
    // Module-wide mode decode
    // ------------------------------------------------------------
    wire logic modeUpDown = countMode == MODE_UPDOWN;
    wire logic modeBidir  = countMode == MODE_BIDIR;
    wire logic modeFreq   = countMode == MODE_FREQ;

    // Narrower pulses are rejected by the filters
    wire logic [FILT_W-1:0] minWidthCyc = modeFreq ? FILT_W'(MIN_PULSE_FREQ_CYC)
                                                   : FILT_W'(MIN_PULSE_CNT_CYC);

    localparam logic [PERIOD_W-1:0] TIMEOUT = PERIOD_W'(FREQ_TIMEOUT_CYC);

    // ------------------------------------------------------------
    // Per-channel logic
    // ------------------------------------------------------------
    for (genvar ch = 0; ch < NCH; ch++) begin : gChan

        logic upLevel;
        logic upRise;
        logic dnLevel;
        logic dnRise;

        pulse_input_filter #(
            .CW (FILT_W)
        ) uUpFilter (
            .clock       (clock),
            .sys_rst     (sys_rst),
            .inPos       (up_pulse_input_pos[ch]),
            .inNeg       (up_pulse_input_neg[ch]),
            .minWidthCyc (minWidthCyc),
            .level_q     (upLevel),
            .rise_q      (upRise)
        );

        pulse_input_filter #(
            .CW (FILT_W)
        ) uDnFilter (
            .clock       (clock),
            .sys_rst     (sys_rst),
            .inPos       (down_or_direction_input_pos[ch]),
            .inNeg       (down_or_direction_input_neg[ch]),
            .minWidthCyc (minWidthCyc),
            .level_q     (dnLevel),
            .rise_q      (dnRise)
        );

        // --------------------------------------------------------
        // Step decode
        // --------------------------------------------------------
        wire logic udUp  = modeUpDown & upRise & ~dnRise;
        wire logic udDn  = modeUpDown & dnRise & ~upRise;
        wire logic biUp  = modeBidir & upRise & dnLevel;
        wire logic biDn  = modeBidir & upRise & ~dnLevel;
        wire logic frUp  = modeFreq & upRise;
        wire logic stepUp = udUp | biUp | frUp;
        wire logic stepDn = udDn | biDn;

        // --------------------------------------------------------
        // Count and overflow tally
        // --------------------------------------------------------
        wire chanCfg_t cfg = chanCfg[ch];
        wire logic [COUNT_W-1:0] cnt = countVal_q[ch];
        wire logic passMax = stepUp && (cnt == COUNT_MAX);
        wire logic passMin = stepDn && (cnt == COUNT_MIN);
        wire logic reload  = loadInitReq[ch] | passMax | passMin;

        wire logic [COUNT_W-1:0] countD =
            reload ? cfg.initValue :
            stepUp ? cnt + COUNT_W'(1) :
            stepDn ? cnt - COUNT_W'(1) : cnt;

        wire logic [TALLY_BITS-1:0] tally = overflowTally_q[ch];
        wire logic [TALLY_BITS-1:0] tallyD =
            loadInitReq[ch] ? '0 :
            passMax ? tally + TALLY_BITS'(1) :
            passMin ? tally - TALLY_BITS'(1) :
            tally;

        always_ff @(posedge clock) begin
            if (sys_rst) begin
                countVal_q[ch]      <= COUNT_RST;
                overflowTally_q[ch] <= '0;
            end else begin
                countVal_q[ch]      <= countD;
                overflowTally_q[ch] <= tallyD;
            end
        end

        // --------------------------------------------------------
        // Limit alarms
        // --------------------------------------------------------
        wire logic hiEn  = cfg.hiState == ALARM_LATCH;
        wire logic loEn  = cfg.loState == ALARM_LATCH;
        wire logic hiHit = hiEn && (cnt >= cfg.hiLimit);
        wire logic loHit = loEn && (cnt <= cfg.loLimit);
        wire logic clr   = clearLatchCtl_q[ch];
        // Set wins over clear; hold until cleared
        wire logic hiD = hiHit | (hiEn & hiAlarm_q[ch] & ~clr);
        wire logic loD = loHit | (loEn & loAlarm_q[ch] & ~clr);

        always_ff @(posedge clock) begin
            if (sys_rst) begin
                hiAlarm_q[ch]       <= 1'b0;
                loAlarm_q[ch]       <= 1'b0;
                clearLatchCtl_q[ch] <= 1'b0;
            end else begin
                hiAlarm_q[ch]       <= hiD;
                loAlarm_q[ch]       <= loD;
                clearLatchCtl_q[ch] <= clearLatchReq[ch] & ~clr;
            end
        end

        // --------------------------------------------------------
        // Alarm forwarding to a digital output
        // --------------------------------------------------------
        wire alarmRoute_t routeD = '{
            active: cfg.hiOutEn & hiD,
            slot:   cfg.hiOutSlot,
            chan:   cfg.hiOutChan
        };

        always_ff @(posedge clock) begin
            if (sys_rst) begin
                hiAlarmRoute_q[ch] <= '0;
            end else begin
                hiAlarmRoute_q[ch] <= routeD;
            end
        end

        // --------------------------------------------------------
        // Frequency meter: period between rising edges
        // --------------------------------------------------------
        logic [PERIOD_W-1:0] periodCnt_q;
        logic                armed_q;
        wire logic timedOut  = periodCnt_q >= TIMEOUT - PERIOD_W'(1);
        wire logic freqEdge  = modeFreq & upRise;

        always_ff @(posedge clock) begin
            if (sys_rst || !modeFreq) begin
                periodCnt_q      <= '0;
                armed_q          <= 1'b0;
                freqPeriod_q[ch] <= PERIOD_RST;
            end else if (freqEdge) begin
                periodCnt_q      <= '0;
                armed_q          <= 1'b1;
                // First edge only starts the measurement
                freqPeriod_q[ch] <= armed_q ? periodCnt_q + PERIOD_W'(1) : PERIOD_RST;
            end else if (timedOut) begin
                // Below the lowest rate: report zero
                armed_q          <= 1'b0;
                freqPeriod_q[ch] <= PERIOD_RST;
            end else begin
                periodCnt_q      <= periodCnt_q + PERIOD_W'(1);
            end
        end

        wire logic unusedUpLevel = upLevel;
    end

endmodule : pulse_counter_overflow_alarm

`default_nettype wire

// >>> sim/pulse_counter_props.sv
// Concurrent checks on channel 0 of the pulse counter and alarm block.
// Assumes binding to the top module; config held steady around alarm edges.
`timescale 1ns/100ps
`default_nettype none
module pulse_counter_props
    import pulse_counter_pkg::*;
#(
    parameter int NCH        = 4,
    parameter int TALLY_BITS = 16
) (
    input wire logic                                       clock,
    input wire logic                                       sys_rst,
    input wire pulse_counter_pkg::countMode_t              countMode,
    input wire pulse_counter_pkg::chanCfg_t [NCH-1:0]      chanCfg,
    input wire logic [NCH-1:0]                             loadInitReq,
    input wire logic [NCH-1:0]                             clearLatchReq,
    input wire logic [NCH-1:0][pulse_counter_pkg::COUNT_W-1:0]  countVal_q,
    input wire logic [NCH-1:0][TALLY_BITS-1:0]             overflowTally_q,
    input wire logic [NCH-1:0]                             hiAlarm_q,
    input wire logic [NCH-1:0]                             loAlarm_q,
    input wire logic [NCH-1:0]                             clearLatchCtl_q,
    input wire pulse_counter_pkg::alarmRoute_t [NCH-1:0]   hiAlarmRoute_q,
    input wire logic [NCH-1:0][pulse_counter_pkg::PERIOD_W-1:0] freqPeriod_q
);
    import pulse_counter_pkg::*;
    wire chanCfg_t                cfg0   = chanCfg[0];
    wire logic [COUNT_W-1:0]      cnt0   = countVal_q[0];
    wire logic [TALLY_BITS-1:0]   tally0 = overflowTally_q[0];
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    clr_self_return_a: assert property (clearLatchCtl_q[0] |=> !clearLatchCtl_q[0])
        else $error("clear control stayed high");
    clr_follows_req_a: assert property (clearLatchReq[0] && !clearLatchCtl_q[0] |=> clearLatchCtl_q[0])
        else $error("clear control missed request");
    hi_alarm_set_a: assert property (cfg0.hiState == ALARM_LATCH && cnt0 >= cfg0.hiLimit
        ##1 cfg0.hiState == ALARM_LATCH |-> hiAlarm_q[0]) else $error("high alarm not set");
    hi_alarm_off_a: assert property (cfg0.hiState == ALARM_DISABLE |=> !hiAlarm_q[0])
        else $error("disabled high alarm raised");
    alarm_hold_a: assert property (hiAlarm_q[0] && !clearLatchCtl_q[0] && cfg0.hiState == ALARM_LATCH
        ##1 cfg0.hiState == ALARM_LATCH |-> hiAlarm_q[0]) else $error("latched alarm dropped");
    hi_clear_a: assert property (clearLatchCtl_q[0] && cnt0 < cfg0.hiLimit |=> !hiAlarm_q[0])
        else $error("high alarm not cleared");
    lo_clear_a: assert property (clearLatchCtl_q[0] && cnt0 > cfg0.loLimit |=> !loAlarm_q[0])
        else $error("low alarm not cleared");
    route_match_a: assert property (hiAlarm_q[0] && cfg0.hiOutEn
        |-> hiAlarmRoute_q[0] == {1'h1, cfg0.hiOutSlot, cfg0.hiOutChan}) else $error("route mismatch");
    route_off_a: assert property (hiAlarmRoute_q[0].active |-> hiAlarm_q[0] && cfg0.hiOutEn)
        else $error("route active without alarm");
    tally_up_a: assert property (!$past(loadInitReq[0]) && tally0 - $past(tally0) == TALLY_BITS'(1)
        |-> $past(cnt0) == COUNT_MAX && cnt0 == $past(cfg0.initValue)) else $error("bad tally increment");
    tally_down_a: assert property (!$past(loadInitReq[0]) && $past(tally0) - tally0 == TALLY_BITS'(1)
        |-> $past(cnt0) == COUNT_MIN && cnt0 == $past(cfg0.initValue)) else $error("bad tally decrement");
    freq_idle_a: assert property (countMode != MODE_FREQ [*2] |-> freqPeriod_q[0] == PERIOD_RST)
        else $error("period outside frequency mode");
    tally_c: cover property (tally0 - $past(tally0) == TALLY_BITS'(1));
    alarm_c: cover property ($rose(hiAlarm_q[0]) && hiAlarmRoute_q[0].active);
    clear_c: cover property (clearLatchCtl_q[0] && loAlarm_q[0]);
endmodule : pulse_counter_props
bind pulse_counter_overflow_alarm pulse_counter_props #(.NCH(NCH), .TALLY_BITS(TALLY_BITS)) pulse_counter_props_inst (
    .clock(clock), .sys_rst(sys_rst), .countMode(countMode), .chanCfg(chanCfg), .loadInitReq(loadInitReq),
    .clearLatchReq(clearLatchReq), .countVal_q(countVal_q), .overflowTally_q(overflowTally_q),
    .hiAlarm_q(hiAlarm_q), .loAlarm_q(loAlarm_q), .clearLatchCtl_q(clearLatchCtl_q),
    .hiAlarmRoute_q(hiAlarmRoute_q), .freqPeriod_q(freqPeriod_q));
`default_nettype wire

// >>> sim/field_pulse_source.sv
// Field pulse source for the up and down input pairs of one channel.
// Assumes the bench calls its tasks; lines change at the falling edge.
`timescale 1ns/100ps
`default_nettype none
module field_pulse_source (
    input  wire logic clock,
    output logic      upPos,
    output logic      upNeg,
    output logic      dnPos,
    output logic      dnNeg
);
    initial begin
        {upPos, upNeg} = 2'h1;
        {dnPos, dnNeg} = 2'h1;
    end
    // Negative line the inverse of the positive one, except in commonMode
    task automatic pulse(input bit up, input bit dn, input int hi, input int lo);
        @(negedge clock);
        if (up) {upPos, upNeg} = 2'h2;
        if (dn) {dnPos, dnNeg} = 2'h2;
        repeat (hi) @(negedge clock);
        if (up) {upPos, upNeg} = 2'h1;
        if (dn) {dnPos, dnNeg} = 2'h1;
        repeat (lo) @(negedge clock);
    endtask : pulse
    task automatic setDir(input bit d);
        @(negedge clock);
        {dnPos, dnNeg} = {d, !d};
        repeat (6) @(negedge clock);
    endtask : setDir
    // Positive line raised with the negative one still high: no active level
    task automatic commonMode(input int hi);
        @(negedge clock);
        upPos = 1'h1;
        repeat (hi) @(negedge clock);
        upPos = 1'h0;
        repeat (6) @(negedge clock);
    endtask : commonMode
endmodule : field_pulse_source
`default_nettype wire

// >>> sim/tb.sv
// Self-checking bench for one channel of the pulse counter and alarm block.
// Assumes shortened filter and timeout parameters; inputs move at falling edge.
`timescale 1ns/100ps
`default_nettype none
module tb;
    import pulse_counter_pkg::*;
    logic                      clock;
    logic                      sys_rst;
    countMode_t                mode;
    chanCfg_t [0:0]            cfg;
    logic                      loadReq, clrReq, upP, upN, dnP, dnN, hiA, loA, clrCtl;
    logic [0:0][COUNT_W-1:0]   cnt;
    logic [0:0][TALLY_W-1:0]   tally;
    alarmRoute_t [0:0]         route;
    logic [0:0][PERIOD_W-1:0]  period;
    int                        fail_count = 0, total_checks = 0, cycles = 0;
    pulse_counter_overflow_alarm #(.NCH(1), .MIN_PULSE_CNT_CYC(4), .MIN_PULSE_FREQ_CYC(8), .FREQ_TIMEOUT_CYC(200))
    pulse_counter_overflow_alarm_inst (.clock(clock), .sys_rst(sys_rst), .countMode(mode), .chanCfg(cfg),
        .loadInitReq(loadReq), .clearLatchReq(clrReq), .up_pulse_input_pos(upP), .up_pulse_input_neg(upN),
        .down_or_direction_input_pos(dnP), .down_or_direction_input_neg(dnN), .countVal_q(cnt),
        .overflowTally_q(tally), .hiAlarm_q(hiA), .loAlarm_q(loA), .clearLatchCtl_q(clrCtl),
        .hiAlarmRoute_q(route), .freqPeriod_q(period));
    field_pulse_source src (.clock(clock), .upPos(upP), .upNeg(upN), .dnPos(dnP), .dnNeg(dnN));
    initial begin
        clock = 1'h0;
        forever #4 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            summarize();
        end
    end
    task automatic summarize;
        if (fail_count == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : summarize
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(negedge clock);
    endtask : tick
    task automatic load(input logic [31:0] v);
        cfg[0].initValue = v;
        loadReq = 1'h1;
        tick(1);
        loadReq = 1'h0;
        tick(1);
    endtask : load
    task automatic clearAlarm;
        clrReq = 1'h1;
        tick(1);
        clrReq = 1'h0;
        check("clear control", clrCtl, 1'h1);
        tick(1);
        check("clear control", clrCtl, 1'h0);
    endtask : clearAlarm
    initial begin
        mode = MODE_UPDOWN;
        cfg = '0;
        loadReq = 1'h0;
        clrReq = 1'h0;
        sys_rst = 1'h1;
        tick(2);
        sys_rst = 1'h0;
        tick(1);
        check("count", cnt[0], COUNT_RST);
        check("tally", tally[0], 16'h0);
        cfg[0].hiLimit = COUNT_MAX;
        cfg[0].hiState = ALARM_LATCH;
        cfg[0].hiOutEn = 1'h1;
        cfg[0].hiOutSlot = 4'h5;
        cfg[0].hiOutChan = 4'h3;
        load(32'hFFFF_FFFE);
        src.pulse(1, 0, 6, 6);
        check("count", cnt[0], COUNT_MAX);
        check("high alarm", hiA, 1'h1);
        check("route", route[0], 9'h153);
        src.pulse(1, 0, 6, 6);
        check("count", cnt[0], 32'hFFFF_FFFE);
        check("tally", tally[0], 16'h1);
        check("high alarm", hiA, 1'h1);
        clearAlarm();
        check("high alarm", hiA, 1'h0);
        check("route active", route[0].active, 1'h0);
        cfg[0].hiState = ALARM_DISABLE;
        cfg[0].hiLimit = COUNT_MIN;
        tick(3);
        check("high alarm", hiA, 1'h0);
        cfg[0].hiOutEn = 1'h0;
        cfg[0].hiState = ALARM_LATCH;
        tick(2);
        check("high alarm", hiA, 1'h1);
        check("route active", route[0].active, 1'h0);
        cfg[0].hiState = ALARM_DISABLE;
        tick(2);
        check("high alarm", hiA, 1'h0);
        cfg[0].loState = ALARM_LATCH;
        load(32'h1);
        src.pulse(0, 1, 6, 6);
        check("count", cnt[0], COUNT_MIN);
        check("low alarm", loA, 1'h1);
        src.pulse(0, 1, 6, 6);
        check("count", cnt[0], 32'h1);
        check("tally", tally[0], 16'hFFFF);
        clearAlarm();
        check("low alarm", loA, 1'h0);
        cfg[0].loState = ALARM_DISABLE;
        load(32'hA);
        src.pulse(1, 1, 6, 6);
        check("count", cnt[0], 32'hA);
        src.pulse(1, 0, 2, 6);
        check("count", cnt[0], 32'hA);
        src.commonMode(6);
        check("count", cnt[0], 32'hA);
        cfg[0].loLimit = 32'hA;
        cfg[0].loState = ALARM_LATCH;
        tick(2);
        check("low alarm", loA, 1'h1);
        cfg[0].loState = ALARM_DISABLE;
        tick(2);
        check("low alarm", loA, 1'h0);
        mode = MODE_BIDIR;
        src.setDir(1);
        src.pulse(1, 0, 6, 6);
        check("count", cnt[0], 32'hB);
        src.setDir(0);
        src.pulse(1, 0, 6, 6);
        check("count", cnt[0], 32'hA);
        mode = MODE_FREQ;
        repeat (3) src.pulse(1, 0, 10, 39);
        check("period", period[0], 32'h32);
        tick(200);
        check("period", period[0], PERIOD_RST);
        mode = MODE_UPDOWN;
        tick(2);
        check("period", period[0], PERIOD_RST);
        summarize();
    end
endmodule : tb
`default_nettype wire
